// ===== tb_top.sv
// Self-checking bench for the timer/watchdog unit top.
// Assumes the offsets and reset values of twu_defines.svh.
`timescale 1ns/1ns
`include "twu_defines.svh"
module tb_top;
    localparam logic [7:0] a_hi  = `TWU_OFF_CNT_HIGH;
    localparam logic [7:0] a_lo  = `TWU_OFF_CNT_LOW;
    localparam logic [7:0] a_pre = `TWU_OFF_PRESCALER;
    localparam logic [7:0] a_ctl = `TWU_OFF_CONTROL;
    localparam logic [7:0] a_wcr = `TWU_OFF_WAIT_CTRL;
    localparam logic [7:0] a_eiv = `TWU_OFF_EXT_VECTOR;
    logic       ref_clk_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic [7:0] addr_i    = 8'h00;
    logic [7:0] wdata_i   = 8'h00;
    logic       wr_i      = 1'b0;
    logic       rd_i      = 1'b0;
    logic       hw_sel    = 1'b1;
    logic       ext_pin   = 1'b0;
    logic       nmi_pin   = 1'b0;
    logic       eoc_en    = 1'b1;
    logic [7:0] rdata_o;
    logic       pin, tout, a0_irq, top_irq, sys_rst, e;
    logic [7:0] d, q;
    int         fails = 0;
    int         checks_done = 0;
    int         n;
    int         rst_cnt = 0;

    always #25 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) if (sys_rst === 1'b1) rst_cnt++;

    twu_timer_watchdog twu_timer_watchdog_inst (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .count_input_pin_i(pin),
        .hw_sw_select_pin_i(hw_sel), .ext_int_pin_i(ext_pin),
        .nmi_pin_i(nmi_pin), .timer_output_pin_o(tout),
        .eoc_irq_en_i(eoc_en), .channel_a0_interrupt_o(a0_irq),
        .top_level_interrupt_o(top_irq), .sys_reset_req_o(sys_rst));
    twu_pin_source twu_pin_source_inst (.ref_clk_i(ref_clk_i), .pin_o(pin));

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i   <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic chk8(input string nm, input logic [7:0] ex,
                        input logic [7:0] got);
        checks_done++;
        if (got !== ex)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic chkn(input string nm, input int ex, input int got);
        checks_done++;
        if (got != ex)
        begin
            fails++;
            $display("[FAIL] %s expected %0d seen %0d", nm, ex, got);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] ex,
                      input string nm);
        logic [7:0] v;
        rd(a, v);
        chk8(nm, ex, v);
    endtask
    // Waits for the next end-of-count pulse, bounded
    task automatic gap(output int c);
        c = 0;
        while (a0_irq !== 1'b1 && c < 4000)
        begin
            @(posedge ref_clk_i);
            c++;
        end
    endtask
    // Clocks between two end-of-count pulses
    task automatic period(output int c);
        gap(c);
        c = 0;
        do
        begin
            @(posedge ref_clk_i);
            c++;
        end while (a0_irq !== 1'b1 && c < 4000);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Whole run is well under this span
    initial
    begin
        #(30000 * 50);
        fails++;
        give_verdict();
    end

    initial
    begin
        repeat (16) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        rc(a_hi, `TWU_RST_CNT_HIGH, "cnt_high");
        rc(a_lo, `TWU_RST_CNT_LOW, "cnt_low");
        rc(a_pre, `TWU_RST_PRESCALER, "prescaler");
        rc(a_ctl, `TWU_RST_CONTROL, "control");
        rc(8'h00, 8'h00, "unmapped");
        chk8("out_idle", 8'h01, {7'h00, tout});
        wr(a_eiv, 8'h00);
        wr(a_pre, 8'h00);
        wr(a_hi, 8'h00);
        wr(a_lo, 8'h03);
        wr(a_ctl, 8'h81);
        period(n);
        chkn("eoc_gap", 16, n);
        chk8("top_irq", 8'h01, {7'h00, top_irq});
        repeat (2) @(posedge ref_clk_i);
        e = tout;
        @(posedge ref_clk_i);
        gap(n);
        repeat (2) @(posedge ref_clk_i);
        chk8("square", {7'h00, ~e}, {7'h00, tout});
        wr(a_pre, 8'h01);
        period(n);
        period(n);
        chkn("pre_gap", 32, n);
        wr(a_lo, 8'h07);
        period(n);
        period(n);
        chkn("new_const", 64, n);
        wr(a_ctl, 8'h85);
        gap(n);
        repeat (2) @(posedge ref_clk_i);
        chk8("pwm_low", 8'h00, {7'h00, tout});
        wr(a_ctl, 8'h87);
        chk8("pwm_hold", 8'h00, {7'h00, tout});
        gap(n);
        repeat (2) @(posedge ref_clk_i);
        chk8("pwm_high", 8'h01, {7'h00, tout});
        wr(a_ctl, 8'h84);
        repeat (2) @(posedge ref_clk_i);
        chk8("out_off", 8'h01, {7'h00, tout});
        eoc_en <= 1'b0;
        gap(n);
        chkn("irq_off", 4000, n);
        eoc_en <= 1'b1;
        wr(a_eiv, 8'h06);
        ext_pin <= 1'b1;
        nmi_pin <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        chk8("pins", 8'h03, {6'h00, a0_irq, top_irq});
        ext_pin <= 1'b0;
        nmi_pin <= 1'b0;
        wr(a_eiv, 8'h00);
        wr(a_ctl, 8'hC0);
        gap(n);
        repeat (3) @(posedge ref_clk_i);
        rc(a_ctl, 8'h40, "single_stop");
        rc(a_lo, 8'h07, "single_reload");
        wr(a_pre, 8'h00);
        wr(a_lo, 8'h01);
        wr(a_ctl, 8'h88);
        n = 0;
        fork
            twu_pin_source_inst.send_edges(8);
            repeat (160)
            begin
                @(posedge ref_clk_i);
                if (a0_irq === 1'b1) n++;
            end
        join
        chkn("events", 4, n);
        wr(a_ctl, 8'h00);
        twu_pin_source_inst.set_level(1'b0);
        wr(a_ctl, 8'h98);
        rd(a_lo, q);
        repeat (40) @(posedge ref_clk_i);
        rc(a_lo, q, "gate_low");
        twu_pin_source_inst.set_level(1'b1);
        period(n);
        chkn("gate_high", 8, n);
        wr(a_ctl, 8'h00);
        wr(a_ctl, 8'hA8);
        rd(a_lo, q);
        repeat (40) @(posedge ref_clk_i);
        rc(a_lo, q, "trig_wait");
        twu_pin_source_inst.send_edges(1);
        period(n);
        chkn("trig_run", 8, n);
        wr(a_ctl, 8'h00);
        wr(a_lo, 8'h10);
        wr(a_wcr, 8'hBF);
        wr(a_wcr, 8'hFF);
        rd(a_wcr, d);
        chk8("wdg_lock", 8'h00, d & 8'h40);
        wr(a_hi, 8'h80);
        repeat (5)
        begin
            repeat (40) @(posedge ref_clk_i);
            wr(a_lo, 8'hAA);
            wr(a_lo, 8'h55);
        end
        chkn("refreshed", 0, rst_cnt);
        n = 0;
        while (rst_cnt == 0 && n < 300)
        begin
            @(posedge ref_clk_i);
            n++;
        end
        chkn("expiry", 1, int'(n > 60 && n < 100));
        rd(`TWU_OFF_FLAGS, d);
        chk8("wdg_flag", 8'h40, d & 8'h40);
        hw_sel    <= 1'b0;
        reset_n_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        wr(a_pre, 8'h00);
        rd(a_lo, q);
        repeat (8) @(posedge ref_clk_i);
        rd(a_lo, d);
        chkn("hw_wdg", 1, int'(q !== d));
        give_verdict();
    end
endmodule // tb_top

// ===== twu_defines.svh
// Register map, field positions, reset values and timing counts
// of the timer/watchdog unit.
// Assumes an 8-bit register port with byte offsets as printed.
`ifndef TWU_DEFINES_SVH
`define TWU_DEFINES_SVH

`define TWU_ADDR_W          8
`define TWU_OFF_CNT_HIGH    8'hF8
`define TWU_OFF_CNT_LOW     8'hF9
`define TWU_OFF_PRESCALER   8'hFA
`define TWU_OFF_CONTROL     8'hFB
`define TWU_OFF_WAIT_CTRL   8'hFC
`define TWU_OFF_EXT_VECTOR  8'hF6
`define TWU_OFF_FLAGS       8'hF2

`define TWU_RST_CNT_HIGH    8'hFF
`define TWU_RST_CNT_LOW     8'hFF
`define TWU_RST_PRESCALER   8'hFF
`define TWU_RST_CONTROL     8'h12
`define TWU_RST_WAIT_CTRL   8'h7F
`define TWU_RST_EXT_VECTOR  8'h06
`define TWU_WDG_CONSTANT    16'hFFFF

`define TWU_CTL_START       7
`define TWU_CTL_SINGLE      6
`define TWU_CTL_MODE_A      5
`define TWU_CTL_MODE_B      4
`define TWU_CTL_IN_EN       3
`define TWU_CTL_OUT_MODE    2
`define TWU_CTL_PWM_LEVEL   1
`define TWU_CTL_OUT_EN      0
`define TWU_WCR_WDG_EN_N    6
`define TWU_EIV_TOP_SEL     2
`define TWU_EIV_A0_SEL      1
`define TWU_FLG_WDG_RESET   6
`define TWU_FLG_EOC_IRQ     0

`define TWU_INTERNAL_CLOCK_DIV      4
`define TWU_SYS_RESET_CYC   4

`endif

// ===== twu_pin_source.sv
// Far-side model of the pulse or gate source on the count input pin.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ns
module twu_pin_source
(
    // Clock
    input  wire logic ref_clk_i,
    // Pin
    output logic      pin_o
);
    initial pin_o = 1'b1;

    // Gate level, held until the next call
    task automatic set_level(input logic lvl);
        @(posedge ref_clk_i);
        pin_o <= lvl;
    endtask

    // Falling edges 17 clocks apart, more than twice the minimum spacing
    task automatic send_edges(input int cnt);
        repeat (cnt)
        begin
            @(posedge ref_clk_i);
            pin_o <= 1'b1;
            repeat (8) @(posedge ref_clk_i);
            pin_o <= 1'b0;
            repeat (8) @(posedge ref_clk_i);
        end
        pin_o <= 1'b1;
    endtask
endmodule // twu_pin_source

// ===== twu_pkg.sv
// Types shared by the timer/watchdog unit modules.
// Assumes twu_defines.svh for numeric constants.
package twu_pkg;
    typedef enum logic [1:0]
    {
        TWU_IN_EVENT   = 2'b00,
        TWU_IN_GATED   = 2'b01,
        TWU_IN_TRIG    = 2'b10,
        TWU_IN_RETRIG  = 2'b11
    } twu_in_mode_t;

    typedef enum logic [1:0]
    {
        TWU_ST_IDLE    = 2'b00,
        TWU_ST_ARMED   = 2'b01,
        TWU_ST_RUN     = 2'b11
    } twu_run_state_t;
endpackage

// ===== twu_tick_gen.sv
`timescale 1ns/1ns
// Internal clock divider by four and the 8-bit prescaler.
// Assumes run is high only in cycles where a count source is active.
module twu_tick_gen
    import twu_pkg::*;
(
    // Clock and reset
    input  wire logic   ref_clk_i,
    input  wire logic   reset_n_i,
    input  wire logic   clk_en_i,
    // Control side
    twu_tick_if.tick    tick
);
`include "twu_defines.svh"

    logic [1:0] div_q;
    logic [7:0] pre_q;
    logic       wrap;

    // Internal clock divided by four (see R02)
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            div_q <= 2'h0;
        else if (clk_en_i)
            div_q <= (div_q == 2'(`TWU_INTERNAL_CLOCK_DIV - 1)) ? 2'h0
                                                      : div_q + 2'h1;
    end

    assign tick.div_tick = (div_q == 2'(`TWU_INTERNAL_CLOCK_DIV - 1));

    // Divide by value plus one; a new value acts at once (see R26) (see R23)
    assign wrap = (pre_q >= tick.pre_value);

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            pre_q <= 8'h00;
        else if (clk_en_i)
        begin
            if (tick.restart)
                pre_q <= 8'h00;
            else if (tick.run)
                pre_q <= wrap ? 8'h00 : pre_q + 8'h01;
        end
    end

    // One counter step per full prescaler period (see R27)
    assign tick.cnt_tick = tick.run && wrap;
endmodule // twu_tick_gen

// ===== twu_tick_if.sv
`timescale 1ns/1ns
// Tick carrier between the top and its prescaler/divider.
// Assumes both ends share ref_clk_i.
interface twu_tick_if;
    logic       run;
    logic       restart;
    logic [7:0] pre_value;
    logic       div_tick;
    logic       cnt_tick;
    modport ctrl (output run, output restart, output pre_value,
                  input div_tick, input cnt_tick);
    modport tick (input run, input restart, input pre_value,
                  output div_tick, output cnt_tick);
endinterface

// ===== twu_timer_watchdog.sv
// Chosen here: strobed register access.
`timescale 1ns/1ns
// Top of the timer/watchdog unit: registers, counter, input modes,
// output modes, end-of-count interrupt routing and watchdog reset.
// Assumes ref_clk_i is the internal clock; pins are asynchronous.
//
// Summary of operation
// (R01) Continuous mode reloads at end of count and runs until start bit clears.
// (R02) Input enable counts pin pulses; otherwise counts internal clock over four.
// (R03) Event mode counts each falling edge of the count input.
// (R04) Source spaces event edges at least eight internal clock periods.
// (R05) Event counting starts at the first edge after start; stops on clear.
// (R06) Gated mode counts clock over four only while input is high.
// (R07) Triggerable mode starts on falling edge after start bit is set.
// (R08) Retriggerable edges reload the count while running; ignored when stopped.
// (R09) Output disabled holds the timer pin high.
// (R10) Square-wave mode toggles the output on every end of count.
// (R11) PWM mode copies the level bit to the output at end of count.
// (R12) Hardware select low enables watchdog after external reset only.
// (R13) Hardware watchdog fixes the constant at FFFFh; enable bit ignored.
// (R14) Watchdog enable bit, once cleared by software, cannot be set again.
// (R15) Clearing the enable bit starts counting regardless of start bit.
// (R16) In watchdog mode only the prescaler constant may change.
// (R17) Watchdog end of count generates a system reset.
// (R18) Watchdog reset sets flag bit six of the flag register.
// (R19) Writing AAh then 55h to the low register reloads the watchdog.
// (R20) Watchdog counts continuously on internal clock, ignoring mode bits.
// (R21) Enabled end-of-count interrupt requests on every end of count.
// (R22) Select bits route end of count or pin; watchdog makes traps.
// (R23) New constant applies at next end of count; prescaler immediately.
// (R24) Single mode stops, reloads and clears start bit at end of count.
// (R25) End of count is detected when the counter is zero.
// (R26) Prescaler divides by its value plus one.
// (R27) Counter decrements once per full prescaler period.
module twu_timer_watchdog
    import twu_pkg::*;
(
    // Clock, reset and enable
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        clk_en_i,
    // Register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    // Pins
    input  wire logic        count_input_pin_i,
    input  wire logic        hw_sw_select_pin_i,
    input  wire logic        ext_int_pin_i,
    input  wire logic        nmi_pin_i,
    output logic             timer_output_pin_o,
    // Interrupt and reset requests
    input  wire logic        eoc_irq_en_i,
    output logic             channel_a0_interrupt_o,
    output logic             top_level_interrupt_o,
    output logic             sys_reset_req_o
);
`include "twu_defines.svh"

    twu_tick_if tk ();

    logic [7:0]  cnt_high_q, cnt_low_q, pre_q, ctl_q;
    logic        wdg_en_n_q, top_sel_q, a0_sel_q;
    logic [15:0] count_q;
    logic        reload_pend_q, aa_seen_q, wdg_flag_q, hw_wdg_q;
    logic        hw_sync1_q, hw_sync2_q, strap_done_q;
    logic [1:0]  strap_wait_q;
    logic        in_sync1_q, in_sync2_q, in_prev_q;
    logic        out_q, a0_q, top_q, rst_q;
    logic [2:0]  rst_cnt_q;
    twu_run_state_t state_q;

    logic        wdg_mode, fall, eoc, in_en, wr_low, wr_high;
    logic        start_bit, start_rise, start_prev_q, retrig;
    twu_in_mode_t mode;

    assign wdg_mode  = hw_wdg_q || !wdg_en_n_q;
    assign in_en     = ctl_q[`TWU_CTL_IN_EN] && !wdg_mode;
    assign mode      = twu_in_mode_t'({ctl_q[`TWU_CTL_MODE_A],
                                       ctl_q[`TWU_CTL_MODE_B]});
    assign start_bit = ctl_q[`TWU_CTL_START];
    assign fall      = in_prev_q && !in_sync2_q;
    assign wr_low    = wr_i && (addr_i == `TWU_OFF_CNT_LOW);
    assign wr_high   = wr_i && (addr_i == `TWU_OFF_CNT_HIGH);
    assign start_rise = start_bit && !start_prev_q;

    // Pin synchronisers: the second stage feeds all logic
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            in_sync1_q <= 1'b1;
            in_sync2_q <= 1'b1;
            in_prev_q  <= 1'b1;
            hw_sync1_q <= 1'b1;
            hw_sync2_q <= 1'b1;
        end
        else if (clk_en_i)
        begin
            in_sync1_q <= count_input_pin_i;
            in_sync2_q <= in_sync1_q;
            in_prev_q  <= in_sync2_q;
            hw_sync1_q <= hw_sync_select();
            hw_sync2_q <= hw_sync1_q;
        end
    end

    function automatic logic hw_sync_select();
        return hw_sw_select_pin_i;
    endfunction

    // Strap caught after external reset; internal resets leave it (see R12)
    // Waits until the synchroniser holds the pin, not its reset value
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            hw_wdg_q     <= 1'b0;
            strap_done_q <= 1'b0;
            strap_wait_q <= 2'h0;
        end
        else if (clk_en_i && !strap_done_q)
        begin
            if (strap_wait_q != 2'h2)
                strap_wait_q <= strap_wait_q + 2'h1;
            else
            begin
                hw_wdg_q     <= !hw_sync2_q;
                strap_done_q <= 1'b1;
            end
        end
    end

    // Run state per input mode (see R05) (see R07) (see R20)
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_q      <= TWU_ST_IDLE;
            start_prev_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            start_prev_q <= start_bit;
            if (wdg_mode)
                state_q <= TWU_ST_RUN;
            else if (!start_bit)
                state_q <= TWU_ST_IDLE;
            else if (state_q == TWU_ST_IDLE)
                state_q <= (in_en && (mode == TWU_IN_EVENT ||
                            mode == TWU_IN_TRIG)) ? TWU_ST_ARMED
                                                   : TWU_ST_RUN;
            else if (state_q == TWU_ST_ARMED && fall)
                state_q <= TWU_ST_RUN;
        end
    end

    // Count source selection (see R02) (see R03) (see R06) (see R15)
    always_comb
    begin
        tk.run = 1'b0;
        if (state_q == TWU_ST_RUN)
        begin
            if (!in_en)
                tk.run = tk.div_tick;
            else
                case (mode)
                    TWU_IN_EVENT:  tk.run = fall;
                    TWU_IN_GATED:  tk.run = tk.div_tick && in_sync2_q;
                    TWU_IN_TRIG,
                    TWU_IN_RETRIG: tk.run = tk.div_tick;
                    default:       tk.run = 1'b0;
                endcase
        end
        else if (state_q == TWU_ST_ARMED && in_en && mode == TWU_IN_EVENT)
            tk.run = fall;                                     // see R05
    end

    // Retrigger ignored unless running (see R08)
    assign retrig     = in_en && mode == TWU_IN_RETRIG && fall &&
                        state_q == TWU_ST_RUN;
    assign tk.restart = retrig;
    assign tk.pre_value = pre_q;
    // End of count at zero (see R25)
    assign eoc = tk.cnt_tick && (count_q == 16'h0000);

    twu_tick_gen u_tick
    (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .clk_en_i  (clk_en_i),
        .tick      (tk)
    );

    // Software registers
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cnt_high_q <= `TWU_RST_CNT_HIGH;
            cnt_low_q  <= `TWU_RST_CNT_LOW;
            pre_q      <= `TWU_RST_PRESCALER;
            ctl_q      <= `TWU_RST_CONTROL;
            wdg_en_n_q <= 1'b1;
            top_sel_q  <= 1'b1;
            a0_sel_q   <= 1'b1;
        end
        else if (clk_en_i)
        begin
            // Prescaler always writable (see R13)
            if (wr_i && addr_i == `TWU_OFF_PRESCALER)
                pre_q <= wdata_i;
            // Constant frozen in watchdog mode (see R16)
            if (wr_high && !wdg_mode)
                cnt_high_q <= wdata_i;
            if (wr_low && !wdg_mode)
                cnt_low_q <= wdata_i;
            if (wr_i && addr_i == `TWU_OFF_CONTROL)
                ctl_q <= wdata_i;
            else if (eoc && ctl_q[`TWU_CTL_SINGLE] && !wdg_mode)
                ctl_q[`TWU_CTL_START] <= 1'b0;                 // see R24
            // Enable bit can only be cleared (see R14)
            if (wr_i && addr_i == `TWU_OFF_WAIT_CTRL &&
                !wdata_i[`TWU_WCR_WDG_EN_N])
                wdg_en_n_q <= 1'b0;
            if (wr_i && addr_i == `TWU_OFF_EXT_VECTOR)
            begin
                top_sel_q <= wdata_i[`TWU_EIV_TOP_SEL];
                a0_sel_q  <= wdata_i[`TWU_EIV_A0_SEL];
            end
        end
    end

    // Refresh sequence tracking (see R19)
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            aa_seen_q <= 1'b0;
        else if (clk_en_i && wr_low)
            aa_seen_q <= (wdata_i == 8'hAA);
    end

    // Constant written while stopped loads at restart, else at next EOC
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            reload_pend_q <= 1'b0;
        else if (clk_en_i)
        begin
            if ((wr_high || wr_low) && !wdg_mode)
                reload_pend_q <= 1'b1;
            else if (eoc || (start_rise && reload_pend_q))
                reload_pend_q <= 1'b0;
        end
    end

    // Down counter
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            count_q <= `TWU_WDG_CONSTANT;
        else if (clk_en_i)
        begin
            if (hw_wdg_q && (eoc || (wr_low && aa_seen_q &&
                wdata_i == 8'h55)))
                count_q <= `TWU_WDG_CONSTANT;                  // see R13
            else if (wdg_mode && wr_low && aa_seen_q &&
                     wdata_i == 8'h55)
                count_q <= {cnt_high_q, cnt_low_q};            // see R19
            else if (eoc || retrig || (start_rise && reload_pend_q) ||
                     (wr_i && addr_i == `TWU_OFF_WAIT_CTRL &&
                      !wdata_i[`TWU_WCR_WDG_EN_N] && !wdg_mode))
                count_q <= {cnt_high_q, cnt_low_q};  // see R01 (see R23)
            else if (tk.cnt_tick)
                count_q <= count_q - 16'h0001;                 // see R27
        end
    end

    // Timer output: high when disabled (see R09) (see R10) (see R11)
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            out_q <= 1'b1;
        else if (clk_en_i)
        begin
            if (!ctl_q[`TWU_CTL_OUT_EN])
                out_q <= 1'b1;
            else if (eoc)
                out_q <= ctl_q[`TWU_CTL_OUT_MODE]
                       ? ctl_q[`TWU_CTL_PWM_LEVEL] : !out_q;
        end
    end

    // Interrupt routing; timer sources vanish in watchdog mode,
    // where only the ext_int_pin_i and nmi_pin_i sources remain (see R21) (see R22)
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            a0_q  <= 1'b0;
            top_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            a0_q  <= a0_sel_q ? ext_int_pin_i
                              : (eoc && eoc_irq_en_i && !wdg_mode);
            top_q <= top_sel_q ? nmi_pin_i
                               : (eoc && eoc_irq_en_i && !wdg_mode);
        end
    end

    // Watchdog system reset pulse and its flag (see R17) (see R18)
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_q      <= 1'b0;
            rst_cnt_q  <= 3'h0;
            wdg_flag_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (wdg_mode && eoc)
            begin
                rst_q      <= 1'b1;
                rst_cnt_q  <= 3'(`TWU_SYS_RESET_CYC);
                wdg_flag_q <= 1'b1;
            end
            else if (rst_cnt_q != 3'h0)
                rst_cnt_q <= rst_cnt_q - 3'h1;
            else
                rst_q <= 1'b0;
            if (wr_i && addr_i == `TWU_OFF_FLAGS &&
                !wdata_i[`TWU_FLG_WDG_RESET] && !(wdg_mode && eoc))
                wdg_flag_q <= 1'b0;
        end
    end

    // Read port, one cycle latency
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rdata_o <= 8'h00;
        else if (clk_en_i)
        begin
            rdata_o <= 8'h00;
            if (rd_i)
                case (addr_i)
                    `TWU_OFF_CNT_HIGH:   rdata_o <= count_q[15:8];
                    `TWU_OFF_CNT_LOW:    rdata_o <= count_q[7:0];
                    `TWU_OFF_PRESCALER:  rdata_o <= pre_q;
                    `TWU_OFF_CONTROL:    rdata_o <= ctl_q;
                    `TWU_OFF_WAIT_CTRL:  rdata_o <= {1'b0, wdg_en_n_q,
                                                     6'h3F};
                    `TWU_OFF_EXT_VECTOR: rdata_o <= {5'h00, top_sel_q,
                                                     a0_sel_q, 1'b0};
                    `TWU_OFF_FLAGS:      rdata_o <= {1'b0, wdg_flag_q,
                                                     6'h00};
                    default:             rdata_o <= 8'h00;
                endcase
        end
    end

    assign timer_output_pin_o     = out_q;
    assign channel_a0_interrupt_o = a0_q;
    assign top_level_interrupt_o  = top_q;
    assign sys_reset_req_o        = rst_q;

    wdg_lock_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        $fell(wdg_en_n_q) |=> always_low_check()) // see R14
        else $error("watchdog enable bit set again");
    function automatic logic always_low_check();
        return !wdg_en_n_q;
    endfunction

    eoc_reset_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && wdg_mode && eoc) |=> rst_q && wdg_flag_q) // see R17
        else $error("no system reset at watchdog end of count");

    out_idle_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && !ctl_q[`TWU_CTL_OUT_EN]) |=> out_q) // see R09
        else $error("timer output not high while disabled");

    square_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && eoc && ctl_q[`TWU_CTL_OUT_EN] &&
         !ctl_q[`TWU_CTL_OUT_MODE]) |=> out_q != $past(out_q)) // see R10
        else $error("square wave did not toggle");

    pwm_copy_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && eoc && ctl_q[`TWU_CTL_OUT_EN] &&
         ctl_q[`TWU_CTL_OUT_MODE]) |=> out_q == $past(ctl_q[1])) // see R11
        else $error("pwm level not copied");

    single_stop_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && eoc && ctl_q[6] && !wdg_mode && !wr_i)
        |=> !ctl_q[`TWU_CTL_START]) // see R24
        else $error("single mode did not clear start bit");

    frozen_const_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (clk_en_i && wdg_mode) |=> $stable(cnt_high_q)) // see R16
        else $error("constant changed in watchdog mode");

    idle_still_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (state_q == TWU_ST_IDLE && !wdg_mode) |-> !tk.cnt_tick) // see R05
        else $error("counter advanced while stopped");
endmodule // twu_timer_watchdog
